/* File: common/scan_seq_cfg.svh */
// Constants for the channel scan sequencer
`ifndef SCAN_SEQ_CFG_SVH
`define SCAN_SEQ_CFG_SVH

`define CH_CODE_W 12
`define SLOT_MSB 11
`define SLOT_LSB 8
`define TENS_MSB 7
`define TENS_LSB 4
`define ONES_MSB 3
`define ONES_LSB 0
`define SLOT_FIRST 4'h1
`define SLOT_LAST 4'h2
`define DIGIT_MAX 4'h9
`define PAIR_TENS_STEP 4'h1
`define CFG_W 10
`define CFG_MODE_MSB 9
`define CFG_MODE_LSB 8
`define AUTOCLEAR_RESET 1'b1

`endif

/* File: common/scan_seq_pkg.sv */
// Types for the channel scan sequencer
package scan_seq_pkg;
    typedef enum logic [1:0] {MODE_2W, MODE_4W, MODE_PAIR_CALC, MODE_RSVD} meas_mode_e;
    typedef enum {S_IDLE, S_PICK, S_OPEN, S_CLOSE, S_MEAS, S_WAIT, S_OPEN_P, S_CLOSE_P,
        S_MEAS_P, S_WAIT_P, S_STORE, S_END} seq_state_e;
endpackage

/* File: logic/channel_scan_sequencer.sv */
// Channel scan sequencer: list storage, relay sequencing, buffer writes and display state
`timescale 1ns/100ps
`include "scan_seq_cfg.svh"
module channel_scan_sequencer
    import scan_seq_pkg::*;
#(
    parameter int LIST_DEPTH = 16,
    parameter int LIST_AW = 4,
    parameter int DATA_W = 24,
    parameter int BUF_AW = 16
)(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic list_clear,
    input wire logic list_wr,
    input wire logic [`CH_CODE_W-1:0] list_ch,
    input wire logic [`CFG_W-1:0] list_cfg,
    input wire logic seq_mode,
    input wire logic scan_start,
    input wire logic autoclear_wr,
    input wire logic autoclear_val,
    input wire logic emul_wr,
    input wire logic emul_slot,
    input wire logic emul_on,
    input wire logic [1:0] slot_present_pin,
    input wire logic meas_done,
    input wire logic [DATA_W-1:0] meas_data,
    output logic relay_open_q,
    output logic relay_close_q,
    output logic relay_pair_q,
    output logic [`CH_CODE_W-1:0] relay_ch_q,
    output logic [`CH_CODE_W-1:0] relay_pair_ch_q,
    output logic meas_req_q,
    output logic [`CFG_W-1:0] meas_cfg_q,
    output logic buf_clear_q,
    output logic buf_wr_q,
    output logic [BUF_AW-1:0] buf_addr_q,
    output logic [DATA_W-1:0] buf_data_q,
    output logic [`CH_CODE_W-1:0] disp_ch_q,
    output logic disp_blank_q,
    output logic busy_q,
    output logic nonseq_q,
    output logic autoclear_q
);
    seq_state_e state_q;
    logic [`CH_CODE_W-1:0] list_q [LIST_DEPTH];
    logic [`CFG_W-1:0] cfg_q [LIST_DEPTH];
    logic [LIST_AW:0] len_q;
    logic [LIST_AW:0] step_q;
    logic [`CH_CODE_W-1:0] last_q;
    logic [`CH_CODE_W-1:0] cur_ch_q;
    logic [`CFG_W-1:0] cur_cfg_q;
    logic closed_q;
    logic [`CH_CODE_W-1:0] closed_ch_q;
    logic closed_pair_q;
    logic [`CH_CODE_W-1:0] closed_pch_q;
    logic have_rd_q;
    logic [`CH_CODE_W-1:0] shown_ch_q;
    logic [DATA_W-1:0] rd_a_q;
    logic [DATA_W-1:0] rd_q;
    logic [BUF_AW-1:0] wptr_q;
    logic [1:0] emul_q;
    logic [1:0] pres_s1_q;
    logic [1:0] pres_s2_q;
    logic seq_q;

    // Sequential pick: smallest code above the last visited one
    logic seq_found;
    logic [LIST_AW-1:0] seq_idx;
    always_comb
    begin
        seq_found = 1'b0;
        seq_idx = '0;
        for (int i = 0; i < LIST_DEPTH; i++)
        begin
            if (i < int'(len_q) && list_q[i] > last_q && (!seq_found || list_q[i] < list_q[seq_idx]))
            begin
                seq_found = 1'b1;
                seq_idx = LIST_AW'(i);
            end
        end
    end

    wire [LIST_AW-1:0] pick_idx = seq_q ? seq_idx : step_q[LIST_AW-1:0];
    wire list_done = seq_q ? !seq_found : (step_q == len_q);
    wire [`CH_CODE_W-1:0] pick_ch = list_q[pick_idx];
    wire [3:0] p_slot = pick_ch[`SLOT_MSB:`SLOT_LSB];
    wire [3:0] p_tens = pick_ch[`TENS_MSB:`TENS_LSB];
    wire [3:0] p_ones = pick_ch[`ONES_MSB:`ONES_LSB];
    wire slot_ok = (p_slot == `SLOT_FIRST) || (p_slot == `SLOT_LAST);
    wire slot_fitted = (p_slot == `SLOT_FIRST) ? (pres_s2_q[0] | emul_q[0]) : (pres_s2_q[1] | emul_q[1]);
    wire digits_ok = (p_tens <= `DIGIT_MAX) && (p_ones <= `DIGIT_MAX);
    wire pick_ok = slot_ok && slot_fitted && digits_ok;
    wire [3:0] c_tens = cur_ch_q[`TENS_MSB:`TENS_LSB];
    wire [3:0] c_ones = cur_ch_q[`ONES_MSB:`ONES_LSB];
    // Only primaries one to ten have a partner; others fall back to a single channel
    wire is_primary = ((c_tens == 4'h0) && (c_ones != 4'h0)) || ((c_tens == 4'h1) && (c_ones == 4'h0));
    wire [`CH_CODE_W-1:0] partner = {cur_ch_q[`SLOT_MSB:`SLOT_LSB], c_tens + `PAIR_TENS_STEP, c_ones};
    wire [1:0] cur_mode = cur_cfg_q[`CFG_MODE_MSB:`CFG_MODE_LSB];
    wire use_pair = (cur_mode == MODE_4W) && is_primary;
    wire use_calc = (cur_mode == MODE_PAIR_CALC) && is_primary;
    wire [DATA_W:0] calc_sum = {1'b0, rd_a_q} + {1'b0, meas_data};
    wire [DATA_W-1:0] calc_avg = calc_sum[DATA_W:1];
    wire start_ok = scan_start && (state_q == S_IDLE);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pres_s1_q <= 2'h0;
            pres_s2_q <= 2'h0;
        end
        else
        begin
            pres_s1_q <= slot_present_pin;
            pres_s2_q <= pres_s1_q;
        end
    end

    // List load; writes are ignored while a scan runs
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            len_q <= '0;
            nonseq_q <= 1'b0;
        end
        else if (state_q == S_IDLE && list_clear)
        begin
            len_q <= '0;
            nonseq_q <= 1'b0;
        end
        else if (state_q == S_IDLE && list_wr && len_q < (LIST_AW+1)'(LIST_DEPTH))
        begin
            list_q[len_q[LIST_AW-1:0]] <= list_ch;
            cfg_q[len_q[LIST_AW-1:0]] <= list_cfg;
            len_q <= len_q + 1'b1;
            if (len_q != '0 && list_ch < list_q[len_q[LIST_AW-1:0] - 1'b1])
                nonseq_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            autoclear_q <= `AUTOCLEAR_RESET;
            emul_q <= 2'h0;
        end
        else
        begin
            if (autoclear_wr)
                autoclear_q <= autoclear_val;
            if (emul_wr)
                emul_q[emul_slot] <= emul_on;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= S_IDLE;
            relay_open_q <= 1'b0;
            relay_close_q <= 1'b0;
            relay_pair_q <= 1'b0;
            relay_ch_q <= '0;
            relay_pair_ch_q <= '0;
            meas_req_q <= 1'b0;
            meas_cfg_q <= '0;
            buf_clear_q <= 1'b0;
            buf_wr_q <= 1'b0;
            buf_addr_q <= '0;
            buf_data_q <= '0;
            disp_ch_q <= '0;
            disp_blank_q <= 1'b0;
            busy_q <= 1'b0;
            seq_q <= 1'b0;
            step_q <= '0;
            last_q <= '0;
            cur_ch_q <= '0;
            cur_cfg_q <= '0;
            closed_q <= 1'b0;
            closed_ch_q <= '0;
            closed_pair_q <= 1'b0;
            closed_pch_q <= '0;
            have_rd_q <= 1'b0;
            shown_ch_q <= '0;
            rd_a_q <= '0;
            rd_q <= '0;
            wptr_q <= '0;
        end
        else
        begin
            relay_open_q <= 1'b0;
            relay_close_q <= 1'b0;
            meas_req_q <= 1'b0;
            buf_clear_q <= 1'b0;
            buf_wr_q <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (start_ok)
                    begin
                        busy_q <= 1'b1;
                        seq_q <= seq_mode;
                        step_q <= '0;
                        last_q <= '0;
                        have_rd_q <= 1'b0;
                        state_q <= S_PICK;
                        if (autoclear_q)
                        begin
                            buf_clear_q <= 1'b1;
                            wptr_q <= '0;
                        end
                    end
                end
                S_PICK:
                begin
                    if (list_done)
                        state_q <= S_END;
                    else if (pick_ok)
                    begin
                        cur_ch_q <= pick_ch;
                        cur_cfg_q <= cfg_q[pick_idx];
                        state_q <= S_OPEN;
                    end
                    else
                    begin
                        step_q <= step_q + 1'b1;
                        last_q <= pick_ch;
                    end
                end
                S_OPEN:
                begin
                    if (closed_q)
                    begin
                        relay_open_q <= 1'b1;
                        relay_ch_q <= closed_ch_q;
                        relay_pair_q <= closed_pair_q;
                        relay_pair_ch_q <= closed_pch_q;
                        closed_q <= 1'b0;
                    end
                    state_q <= S_CLOSE;
                end
                S_CLOSE:
                begin
                    relay_close_q <= 1'b1;
                    relay_ch_q <= cur_ch_q;
                    relay_pair_q <= use_pair;
                    relay_pair_ch_q <= partner;
                    closed_q <= 1'b1;
                    closed_ch_q <= cur_ch_q;
                    closed_pair_q <= use_pair;
                    closed_pch_q <= partner;
                    // Prior reading goes up only once this channel is closed
                    disp_ch_q <= have_rd_q ? shown_ch_q : cur_ch_q;
                    disp_blank_q <= !have_rd_q;
                    state_q <= S_MEAS;
                end
                S_MEAS:
                begin
                    meas_req_q <= 1'b1;
                    meas_cfg_q <= cur_cfg_q;
                    state_q <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (meas_done)
                    begin
                        rd_a_q <= meas_data;
                        rd_q <= meas_data;
                        // Blank may only stand while the shown channel awaits its reading
                        disp_blank_q <= 1'b0;
                        state_q <= use_calc ? S_OPEN_P : S_STORE;
                    end
                end
                S_OPEN_P:
                begin
                    relay_open_q <= 1'b1;
                    relay_ch_q <= cur_ch_q;
                    relay_pair_q <= 1'b0;
                    closed_q <= 1'b0;
                    state_q <= S_CLOSE_P;
                end
                S_CLOSE_P:
                begin
                    relay_close_q <= 1'b1;
                    relay_ch_q <= partner;
                    closed_q <= 1'b1;
                    closed_ch_q <= partner;
                    closed_pair_q <= 1'b0;
                    state_q <= S_MEAS_P;
                end
                S_MEAS_P:
                begin
                    meas_req_q <= 1'b1;
                    meas_cfg_q <= cur_cfg_q;
                    state_q <= S_WAIT_P;
                end
                S_WAIT_P:
                begin
                    if (meas_done)
                    begin
                        rd_q <= calc_avg;
                        state_q <= S_STORE;
                    end
                end
                S_STORE:
                begin
                    buf_wr_q <= 1'b1;
                    buf_addr_q <= wptr_q;
                    buf_data_q <= rd_q;
                    wptr_q <= wptr_q + 1'b1;
                    have_rd_q <= 1'b1;
                    shown_ch_q <= cur_ch_q;
                    step_q <= step_q + 1'b1;
                    last_q <= cur_ch_q;
                    state_q <= S_PICK;
                end
                S_END:
                begin
                    if (closed_q)
                    begin
                        relay_open_q <= 1'b1;
                        relay_ch_q <= closed_ch_q;
                        relay_pair_q <= closed_pair_q;
                        relay_pair_ch_q <= closed_pch_q;
                        closed_q <= 1'b0;
                    end
                    if (have_rd_q)
                    begin
                        disp_ch_q <= shown_ch_q;
                        disp_blank_q <= 1'b0;
                    end
                    busy_q <= 1'b0;
                    state_q <= S_IDLE;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    logic [`CH_CODE_W-1:0] prev_close_q;
    logic seen_close_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_close_q <= '0;
            seen_close_q <= 1'b0;
        end
        else if (start_ok)
            seen_close_q <= 1'b0;
        else if (state_q == S_CLOSE)
        begin
            prev_close_q <= cur_ch_q;
            seen_close_q <= 1'b1;
        end
    end

    property p_meas_after_close;
        @(posedge mclk) disable iff (!rstn) meas_req_q |-> $past(relay_close_q);
    endproperty
    a_meas_after_close: assert property (p_meas_after_close) else $error("measure without close");

    property p_slot_range;
        @(posedge mclk) disable iff (!rstn)
        relay_close_q |-> relay_ch_q[11:8] == 4'h1 || relay_ch_q[11:8] == 4'h2;
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("bad slot closed");

    property p_end_open;
        @(posedge mclk) disable iff (!rstn) $fell(busy_q) |-> !closed_q && state_q == S_IDLE;
    endproperty
    a_end_open: assert property (p_end_open) else $error("channel left closed");

    property p_autoclear;
        @(posedge mclk) disable iff (!rstn) start_ok && autoclear_q |=> buf_clear_q && wptr_q == '0;
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("buffer not cleared");

    property p_store;
        @(posedge mclk) disable iff (!rstn)
        state_q == S_WAIT && meas_done && !use_calc |-> ##2 buf_wr_q && buf_data_q == $past(meas_data, 2);
    endproperty
    a_store: assert property (p_store) else $error("reading not stored");

    property p_append;
        @(posedge mclk) disable iff (!rstn) start_ok && !autoclear_q |=> !buf_clear_q && $stable(wptr_q);
    endproperty
    a_append: assert property (p_append) else $error("append lost");

    property p_pair;
        @(posedge mclk) disable iff (!rstn)
        relay_close_q && relay_pair_q |-> relay_pair_ch_q[7:4] == relay_ch_q[7:4] + 4'h1
            && relay_pair_ch_q[3:0] == relay_ch_q[3:0] && relay_ch_q[7:0] <= 8'h10;
    endproperty
    a_pair: assert property (p_pair) else $error("bad pair");

    property p_seq_order;
        @(posedge mclk) disable iff (!rstn)
        state_q == S_CLOSE && seq_q && seen_close_q |-> cur_ch_q > prev_close_q;
    endproperty
    a_seq_order: assert property (p_seq_order) else $error("sequential order broken");

    property p_blank;
        @(posedge mclk) disable iff (!rstn) disp_blank_q && busy_q |-> closed_q && disp_ch_q == closed_ch_q;
    endproperty
    a_blank: assert property (p_blank) else $error("blank display mismatch");

    property p_calc_order;
        @(posedge mclk) disable iff (!rstn) state_q == S_MEAS_P |-> relay_close_q && $past(relay_open_q);
    endproperty
    a_calc_order: assert property (p_calc_order) else $error("partner closed before primary opened");
endmodule

/* File: sim/scan_front_end_model.sv */
// Behavioural relay module and measurement front end
`timescale 1ns/100ps
module scan_front_end_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] lat,
    input wire logic relay_open_q,
    input wire logic relay_close_q,
    input wire logic [11:0] relay_ch_q,
    input wire logic meas_req_q,
    input wire logic [9:0] meas_cfg_q,
    output logic meas_done,
    output logic [23:0] meas_data,
    output logic [7:0] viol,
    output logic closed_q
);
    logic [11:0] ch_q;
    logic [9:0] cfg_q;
    logic pend_q;
    logic [3:0] cnt_q;

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            closed_q <= 1'b0;
            pend_q <= 1'b0;
            meas_done <= 1'b0;
            meas_data <= 24'h000000;
            viol <= 8'h00;
            cnt_q <= 4'h0;
        end
        else
        begin
            meas_done <= 1'b0;
            // Data is only valid with done; scramble it otherwise
            meas_data <= ~meas_data;
            if (relay_open_q)
                closed_q <= 1'b0;
            if (relay_close_q)
            begin
                // Closing over a closed channel means no open came first
                if (closed_q && !relay_open_q)
                    viol <= viol + 8'h01;
                closed_q <= 1'b1;
                ch_q <= relay_ch_q;
            end
            if (meas_req_q)
            begin
                if (!closed_q)
                    viol <= viol + 8'h01;
                pend_q <= 1'b1;
                cnt_q <= 4'h0;
                cfg_q <= meas_cfg_q;
            end
            else if (pend_q)
            begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == lat)
                begin
                    pend_q <= 1'b0;
                    meas_done <= 1'b1;
                    meas_data <= {2'b00, cfg_q, ch_q};
                end
            end
        end
    end
endmodule

/* File: sim/channel_scan_sequencer_tb.sv */
// Self-checking bench for the channel scan sequencer
`timescale 1ns/100ps
module channel_scan_sequencer_tb;
    import scan_seq_pkg::*;
    logic mclk = 1'b0, rstn = 1'b0, list_clear = 1'b0, list_wr = 1'b0, seq_mode = 1'b0, scan_start = 1'b0;
    logic autoclear_wr = 1'b0, autoclear_val = 1'b1, emul_wr = 1'b0, emul_slot = 1'b0, emul_on = 1'b0;
    logic [11:0] list_ch = 12'h000;
    logic [9:0] list_cfg = 10'h000;
    logic [1:0] slot_present_pin = 2'h1;
    logic [3:0] lat = 4'h0;
    logic meas_done, relay_open_q, relay_close_q, relay_pair_q, meas_req_q, buf_clear_q, buf_wr_q;
    logic disp_blank_q, busy_q, nonseq_q, autoclear_q, closed_q;
    logic [23:0] meas_data, buf_data_q;
    logic [11:0] relay_ch_q, relay_pair_ch_q, disp_ch_q;
    logic [9:0] meas_cfg_q;
    logic [15:0] buf_addr_q;
    logic [7:0] viol;
    int n_fail = 0, checked = 0, n_clr = 0;
    logic [11:0] closes[$], pairs[$];
    logic [23:0] words[$];
    logic [15:0] addrs[$];

    channel_scan_sequencer dut (.mclk(mclk), .rstn(rstn), .list_clear(list_clear), .list_wr(list_wr),
        .list_ch(list_ch), .list_cfg(list_cfg), .seq_mode(seq_mode), .scan_start(scan_start),
        .autoclear_wr(autoclear_wr), .autoclear_val(autoclear_val), .emul_wr(emul_wr), .emul_slot(emul_slot),
        .emul_on(emul_on), .slot_present_pin(slot_present_pin), .meas_done(meas_done), .meas_data(meas_data),
        .relay_open_q(relay_open_q), .relay_close_q(relay_close_q), .relay_pair_q(relay_pair_q),
        .relay_ch_q(relay_ch_q), .relay_pair_ch_q(relay_pair_ch_q), .meas_req_q(meas_req_q),
        .meas_cfg_q(meas_cfg_q), .buf_clear_q(buf_clear_q), .buf_wr_q(buf_wr_q), .buf_addr_q(buf_addr_q),
        .buf_data_q(buf_data_q), .disp_ch_q(disp_ch_q), .disp_blank_q(disp_blank_q), .busy_q(busy_q),
        .nonseq_q(nonseq_q), .autoclear_q(autoclear_q));

    scan_front_end_model fe (.mclk(mclk), .rstn(rstn), .lat(lat), .relay_open_q(relay_open_q),
        .relay_close_q(relay_close_q), .relay_ch_q(relay_ch_q), .meas_req_q(meas_req_q),
        .meas_cfg_q(meas_cfg_q), .meas_done(meas_done), .meas_data(meas_data), .viol(viol), .closed_q(closed_q));

    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (relay_close_q)
            closes.push_back(relay_ch_q);
        if (relay_close_q && relay_pair_q)
            pairs.push_back(relay_pair_ch_q);
        if (buf_clear_q)
            n_clr++;
        if (buf_wr_q)
        begin
            words.push_back(buf_data_q);
            addrs.push_back(buf_addr_q);
        end
    end

    task report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [23:0] rd(input logic [11:0] ch, input logic [9:0] cfg);
        return {2'b00, cfg, ch};
    endfunction

    task add(input logic [11:0] ch, input logic [9:0] cfg);
        list_ch = ch;
        list_cfg = cfg;
        list_wr = 1'b1;
        @(posedge mclk); #1;
        list_wr = 1'b0;
        @(posedge mclk); #1;
    endtask

    task new_list;
        list_clear = 1'b1;
        @(posedge mclk); #1;
        list_clear = 1'b0;
        @(posedge mclk); #1;
    endtask

    // Runs one scan, then checks nothing is left closed and no close skipped its open
    task scan(input logic seq);
        int i;
        closes.delete();
        pairs.delete();
        words.delete();
        addrs.delete();
        n_clr = 0;
        seq_mode = seq;
        scan_start = 1'b1;
        @(posedge mclk); #1;
        scan_start = 1'b0;
        @(posedge mclk); #1;
        for (i = 0; i < 2000 && busy_q !== 1'b0; i++)
        begin
            @(posedge mclk);
            #1;
        end
        // The final open pulse reaches the relay model one edge after busy drops
        @(posedge mclk);
        #1;
        chk(busy_q, 1'b0);
        chk(closed_q, 1'b0);
        chk(viol, 8'h00);
    endtask

    task t_order;
        new_list();
        add(12'h101, 10'h011);
        add(12'h102, 10'h022);
        add(12'h105, 10'h033);
        add(12'h103, 10'h044);
        lat = 4'h7;
        scan(1'b0);
        chk(nonseq_q, 1'b1);
        chk(n_clr, 1);
        chk(closes.size(), 4);
        chk({closes[0], closes[1], closes[2], closes[3]}, 48'h101102105103);
        chk(words.size(), 4);
        chk(words[2], rd(12'h105, 10'h033));
        chk(words[3], rd(12'h103, 10'h044));
        chk(addrs[3], 16'h0003);
        chk(disp_ch_q, 12'h103);
        chk(disp_blank_q, 1'b0);
    endtask

    task t_seq;
        lat = 4'h0;
        scan(1'b1);
        chk({closes[0], closes[1], closes[2], closes[3]}, 48'h101102103105);
        chk(addrs[0], 16'h0000);
        chk(words[3], rd(12'h105, 10'h033));
    endtask

    task t_append;
        autoclear_val = 1'b0;
        autoclear_wr = 1'b1;
        @(posedge mclk); #1;
        autoclear_wr = 1'b0;
        @(posedge mclk); #1;
        chk(autoclear_q, 1'b0);
        scan(1'b0);
        chk(n_clr, 0);
        chk(addrs[0], 16'h0004);
        chk(addrs[3], 16'h0007);
    endtask

    task t_four;
        new_list();
        add(12'h103, 10'h155);
        add(12'h110, 10'h166);
        scan(1'b0);
        chk(closes.size(), 2);
        chk(pairs.size(), 2);
        chk({pairs[0], pairs[1]}, 24'h113120);
        chk(words[0], rd(12'h103, 10'h155));
    endtask

    task t_calc;
        logic [24:0] s;
        new_list();
        add(12'h102, 10'h277);
        lat = 4'h3;
        scan(1'b0);
        s = {1'b0, rd(12'h102, 10'h277)} + {1'b0, rd(12'h112, 10'h277)};
        chk({closes[0], closes[1]}, 24'h102112);
        chk(words.size(), 1);
        chk(words[0], s[24:1]);
    endtask

    task t_emul;
        new_list();
        add(12'h201, 10'h388);
        add(12'h301, 10'h099);
        add(12'h1A1, 10'h099);
        scan(1'b0);
        chk(closes.size(), 0);
        emul_slot = 1'b1;
        emul_on = 1'b1;
        emul_wr = 1'b1;
        @(posedge mclk); #1;
        emul_wr = 1'b0;
        @(posedge mclk); #1;
        scan(1'b0);
        chk(closes.size(), 1);
        chk(closes[0], 12'h201);
        chk(words[0], rd(12'h201, 10'h388));
    endtask

    initial
    begin
        #(5 * 20000);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (10) @(posedge mclk);
        #1 rstn = 1'b1;
        chk(autoclear_q, 1'b1);
        chk(busy_q, 1'b0);
        repeat (3) @(posedge mclk);
        #1;
        t_order();
        t_seq();
        t_append();
        autoclear_val = 1'b1;
        autoclear_wr = 1'b1;
        @(posedge mclk); #1;
        autoclear_wr = 1'b0;
        t_four();
        t_calc();
        t_emul();
        report_and_stop();
    end
endmodule
